// file: tlt_map.svh
`ifndef TLT_MAP_SVH
`define TLT_MAP_SVH
// Register byte offsets.
`define TLT_ADDR_CTRL      12'h000
`define TLT_ADDR_LOOP      12'h004
`define TLT_ADDR_IDLE      12'h008
`define TLT_ADDR_SIM       12'h00c
`define TLT_ADDR_SLIP      12'h010
`define TLT_ADDR_FERR      12'h014
`define TLT_ADDR_CVERR     12'h018
`define TLT_ADDR_CRCERR    12'h01c
`define TLT_ADDR_DEFECT    12'h020
`define TLT_ADDR_STATUS    12'h024
// Control register bit positions.
`define TLT_CTRL_LL        0
`define TLT_CTRL_XAIS      1
`define TLT_CTRL_J1        2
`define TLT_CTRL_ESF       3
`define TLT_CTRL_B8ZS      4
// Loop register fields.
`define TLT_LOOP_EN        5
`define TLT_LOOP_SLOT_W    5
`define TLT_SLOTS          5'h18
// Defect insertion bits.
`define TLT_DEF_FAS        0
`define TLT_DEF_MF         1
`define TLT_DEF_CRC        2
`define TLT_DEF_CAS        3
`define TLT_DEF_PRBS       4
`define TLT_DEF_BPV        5
`define TLT_DEF_W          6
// Alarm simulation and remote alarm length.
`define TLT_SIM_STEPS      4'h8
`define TLT_RA_LEN         4'hd
// Slip status bits.
`define TLT_SLIP_RX        0
`define TLT_SLIP_TX        1
`endif

// file: tlt_pkg.sv
package tlt_pkg;
   typedef struct packed {
      logic lossOfSignal;
      logic ais;
      logic lossOfFrame;
      logic remoteAlarm;
   } tlt_alarm_t;
   typedef struct packed {
      logic [31:0] data;
      logic        valid;
   } tlt_word_t;
   typedef enum logic [1:0] {WR_IDLE, WR_RESP} tlt_wr_state_t;
endpackage

// file: tlt_loop_alarm.sv
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "tlt_map.svh"
// What this block does
// - Local loop feeds system transmit into receiver.
// - Line transmit stays unchanged during local loop.
// - Remote AIS send leaves looped data alone.
// - Local loop entry forces out-of-frame until resync.
// - Channel loop only while enable bit set.
// - Any of 24 slots loopable to system.
// - Exactly one slot, chosen by slot field.
// - Looped slot sends idle code on line.
// - Simulation masks real alarms, traffic continues.
// - Setting simulation bit starts alarm simulation.
// - Each set write increments step counter; the write at step 8 returns it to zero.
// - Simulated code and CRC errors only where mode applies.
// - Signal alarms clear at defined steps.
// - Simulated slips clear on slip register read.
// - Simulated counts clear on counter read.
// - Defect register inserts transmit defects until the next framing bit clears it.
// - J1 select bit chooses J1 globally.
// - J1 CRC6 covers framing and datalink bits.
// - J1 remote alarm is thirteen ones.
module tlt_loop_alarm (
   // Clock and reset.
   input  wire logic                  ref_clk,
   input  wire logic                  rst,
   // AXI4-Lite write address, data and response.
   input  wire logic [11:0]           s_axi_awaddr,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   // AXI4-Lite read.
   input  wire logic [11:0]           s_axi_araddr,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   // Frame timing from the framer core.
   input  wire logic                  bitStrobe,
   input  wire logic [4:0]            slotIndex,
   input  wire logic [2:0]            bitIndex,
   input  wire logic                  framingBitTime,
   input  wire logic                  dlBitTime,
   input  wire logic                  rxInFrame,
   // Data paths.
   input  wire logic                  system_tx_data_in,
   input  wire logic                  lineRxBit,
   input  wire logic                  coreRxBit,
   input  wire logic                  coreTxBit,
   output logic                       receiverInBit,
   output logic                       system_rx_data_out,
   output logic                       lineTxBit,
   // Real alarm and event inputs.
   input  wire tlt_pkg::tlt_alarm_t   realAlarm,
   input  wire logic                  realRxSlip,
   input  wire logic                  realTxSlip,
   input  wire logic                  realFrameErr,
   input  wire logic                  realCodeErr,
   input  wire logic                  realCrcErr,
   // Alarm and mode outputs.
   output tlt_pkg::tlt_alarm_t        reportAlarm,
   output logic                       sendRemoteAlarm,
   output logic                       forceOutOfFrame,
   output logic                       japanModeOut,
   output logic                       crcIncludeFsDl,
   output logic                       crcRemoteAlarmLenOut,
   output logic                       remoteAlarmDetected
);
   import tlt_pkg::*;

   logic [7:0]  ctrl_ff;
   logic [5:0]  loop_ff;
   logic [7:0]  idle_ff;
   logic [3:0]  alarm_sim_counter_ff;
   logic [1:0]  slip_interrupt_status_ff;
   logic [15:0] ferr_ff, cverr_ff, crcerr_ff;
   logic [5:0]  defect_insert_control_ff;
   logic [3:0]  raOnes_ff;
   logic        oof_ff;
   logic        llPrev_ff;
   tlt_wr_state_t wrState_ff;
   logic        awHeld_ff, wHeld_ff;
   logic [11:0] awAddr_ff;
   logic [31:0] wData_ff;
   logic [3:0]  wStrb_ff;

   // Step-dependent simulated alarm table; signal alarms clear themselves at later steps.
   function automatic tlt_alarm_t simAlarms(input logic [3:0] step);
      tlt_alarm_t a;
      a = '0;
      case (step)
         4'h1: a.lossOfSignal = 1'b1;
         4'h2: a.ais          = 1'b1;
         4'h3: a.lossOfFrame  = 1'b1;
         4'h4: a.remoteAlarm  = 1'b1;
         default: a = '0;
      endcase
      return a;
   endfunction

   // Saturating 16-bit increment used by every error counter.
   function automatic logic [15:0] satInc(input logic [15:0] v, input logic ev);
      return (ev && v != 16'hffff) ? v + 16'h0001 : v;
   endfunction

   wire localLoop    = ctrl_ff[`TLT_CTRL_LL];
   wire remoteAis    = ctrl_ff[`TLT_CTRL_XAIS];
   wire japanMode    = ctrl_ff[`TLT_CTRL_J1];
   wire esfMode      = ctrl_ff[`TLT_CTRL_ESF];
   wire simActive    = alarm_sim_counter_ff != 4'h0;
   wire chanLoop     = loop_ff[`TLT_LOOP_EN];
   wire [4:0] loopSlot = loop_ff[4:0];
   wire slotHit      = chanLoop && loopSlot < `TLT_SLOTS && slotIndex == loopSlot;

   // AXI write path: address and data accepted in either order.
   wire awTake  = s_axi_awvalid && s_axi_awready;
   wire wTake   = s_axi_wvalid && s_axi_wready;
   wire haveAw  = awHeld_ff || awTake;
   wire haveW   = wHeld_ff || wTake;
   wire wrFire  = wrState_ff == WR_IDLE && haveAw && haveW;
   wire [11:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
   wire [31:0] wrData = wHeld_ff ? wData_ff : s_axi_wdata;
   wire [3:0]  wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
   wire wrByte0 = wrFire && wrStrb[0];
   wire wrCtrl  = wrByte0 && wrAddr == `TLT_ADDR_CTRL;
   wire wrLoop  = wrByte0 && wrAddr == `TLT_ADDR_LOOP;
   wire wrIdle  = wrByte0 && wrAddr == `TLT_ADDR_IDLE;
   wire wrSim   = wrByte0 && wrAddr == `TLT_ADDR_SIM;
   wire wrDef   = wrByte0 && wrAddr == `TLT_ADDR_DEFECT;
   wire wrMapped = wrAddr == `TLT_ADDR_CTRL || wrAddr == `TLT_ADDR_LOOP || wrAddr == `TLT_ADDR_IDLE
                || wrAddr == `TLT_ADDR_SIM || wrAddr == `TLT_ADDR_DEFECT;
   wire simStepWr = wrSim && wrData[0];

   // AXI read path.
   wire arTake  = s_axi_arvalid && s_axi_arready;
   wire rdSlip  = arTake && s_axi_araddr == `TLT_ADDR_SLIP;
   wire rdFerr  = arTake && s_axi_araddr == `TLT_ADDR_FERR;
   wire rdCverr = arTake && s_axi_araddr == `TLT_ADDR_CVERR;
   wire rdCrc   = arTake && s_axi_araddr == `TLT_ADDR_CRCERR;
   logic [31:0] rdMux;
   logic        rdOk;
   always_comb begin
      rdOk  = 1'b1;
      rdMux = 32'h0000_0000;
      case (s_axi_araddr)
         `TLT_ADDR_CTRL:   rdMux = {24'h000000, ctrl_ff};
         `TLT_ADDR_LOOP:   rdMux = {26'h0000000, loop_ff};
         `TLT_ADDR_IDLE:   rdMux = {24'h000000, idle_ff};
         `TLT_ADDR_SIM:    rdMux = {27'h0000000, alarm_sim_counter_ff, 1'b0};
         `TLT_ADDR_SLIP:   rdMux = {30'h00000000, slip_interrupt_status_ff};
         `TLT_ADDR_FERR:   rdMux = {16'h0000, ferr_ff};
         `TLT_ADDR_CVERR:  rdMux = {16'h0000, cverr_ff};
         `TLT_ADDR_CRCERR: rdMux = {16'h0000, crcerr_ff};
         `TLT_ADDR_DEFECT: rdMux = {26'h0000000, defect_insert_control_ff};
         `TLT_ADDR_STATUS: rdMux = {28'h0000000, reportAlarm};
         default:          rdOk  = 1'b0;
      endcase
   end

   // Simulated events per step; slips and counts appear at their own steps.
   wire simEvStep  = simStepWr;
   wire [3:0] nxtStep = alarm_sim_counter_ff + 4'h1;
   wire simSlips   = simEvStep && nxtStep == 4'h5;
   wire simFerr    = simEvStep && nxtStep == 4'h6;
   wire simCverr   = simEvStep && nxtStep == 4'h7 && ctrl_ff[`TLT_CTRL_B8ZS];
   wire simCrc     = simEvStep && nxtStep == `TLT_SIM_STEPS && esfMode;
   tlt_alarm_t sa;
   always_comb begin
      sa = simAlarms(alarm_sim_counter_ff);
   end

   // Remote alarm detector in the datalink channel; J1 needs thirteen ones.
   wire raBit  = bitStrobe && dlBitTime;
   wire raFull = raOnes_ff == `TLT_RA_LEN;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= 8'h00;
         loop_ff <= 6'h00;
         idle_ff <= 8'h00;
         defect_insert_control_ff <= 6'h00;
      end else begin
         if (wrCtrl) ctrl_ff <= wrData[7:0];
         if (wrLoop) loop_ff <= wrData[5:0];
         if (wrIdle) idle_ff <= wrData[7:0];
         if (wrDef) defect_insert_control_ff <= wrData[5:0];
         else if (bitStrobe && framingBitTime) defect_insert_control_ff <= 6'h00;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         alarm_sim_counter_ff <= 4'h0;
         slip_interrupt_status_ff <= 2'h0;
         ferr_ff <= 16'h0000;
         cverr_ff <= 16'h0000;
         crcerr_ff <= 16'h0000;
      end else begin
         if (simStepWr) alarm_sim_counter_ff <= (nxtStep > `TLT_SIM_STEPS) ? 4'h0 : nxtStep;
         // Set wins over the read clear so no slip is lost.
         slip_interrupt_status_ff <= (rdSlip ? 2'h0 : slip_interrupt_status_ff)
            | {simSlips || (!simActive && realTxSlip), simSlips || (!simActive && realRxSlip)};
         ferr_ff   <= satInc(rdFerr ? 16'h0000 : ferr_ff, simFerr || (!simActive && realFrameErr));
         cverr_ff  <= satInc(rdCverr ? 16'h0000 : cverr_ff, simCverr || (!simActive && realCodeErr));
         crcerr_ff <= satInc(rdCrc ? 16'h0000 : crcerr_ff, simCrc || (!simActive && realCrcErr));
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         raOnes_ff <= 4'h0;
         oof_ff <= 1'b0;
         llPrev_ff <= 1'b0;
      end else begin
         if (raBit) raOnes_ff <= !coreRxBit ? 4'h0 : (raFull ? raOnes_ff : raOnes_ff + 4'h1);
         llPrev_ff <= localLoop;
         // Entering local loop forces loss of frame until the receiver reframes.
         if (localLoop && !llPrev_ff) oof_ff <= 1'b1;
         else if (rxInFrame) oof_ff <= 1'b0;
      end
   end

   // Datapath outputs, all registered.
   wire defFas  = defect_insert_control_ff[`TLT_DEF_FAS] && framingBitTime;
   wire defMf   = defect_insert_control_ff[`TLT_DEF_MF] && framingBitTime;
   wire defCrc  = defect_insert_control_ff[`TLT_DEF_CRC] && dlBitTime;
   wire defCas  = defect_insert_control_ff[`TLT_DEF_CAS] && bitIndex == 3'h7;
   wire defPrbs = defect_insert_control_ff[`TLT_DEF_PRBS] && bitIndex == 3'h0;
   wire defBpv  = defect_insert_control_ff[`TLT_DEF_BPV];
   wire defFlip = defFas | defMf | defCrc | defCas | defPrbs | defBpv;
   wire lineBase = slotHit ? idle_ff[3'h7 - bitIndex] : coreTxBit;
   wire nxtLine  = remoteAis ? 1'b1 : (lineBase ^ defFlip);
   wire nxtRecv  = localLoop ? system_tx_data_in : lineRxBit;
   wire nxtRdo   = slotHit ? system_tx_data_in : coreRxBit;
   wire simOn    = simActive;
   tlt_alarm_t nxtRep;
   assign nxtRep = simOn ? sa : realAlarm;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         receiverInBit <= 1'b0;
         system_rx_data_out <= 1'b1;
         lineTxBit <= 1'b0;
         reportAlarm <= '0;
         sendRemoteAlarm <= 1'b0;
         forceOutOfFrame <= 1'b0;
         japanModeOut <= 1'b0;
         crcIncludeFsDl <= 1'b0;
         crcRemoteAlarmLenOut <= 1'b0;
         remoteAlarmDetected <= 1'b0;
      end else begin
         receiverInBit <= nxtRecv;
         system_rx_data_out <= nxtRdo;
         lineTxBit <= nxtLine;
         reportAlarm <= nxtRep;
         // Real alarms are not passed on to the far end during simulation.
         sendRemoteAlarm <= !simOn && (realAlarm.lossOfSignal || realAlarm.lossOfFrame);
         forceOutOfFrame <= oof_ff;
         japanModeOut <= japanMode;
         crcIncludeFsDl <= japanMode;
         crcRemoteAlarmLenOut <= japanMode;
         remoteAlarmDetected <= japanMode && raFull;
      end
   end

   // AXI handshakes.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrState_ff <= WR_IDLE;
         awHeld_ff <= 1'b0;
         wHeld_ff <= 1'b0;
         awAddr_ff <= 12'h000;
         wData_ff <= 32'h0000_0000;
         wStrb_ff <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else begin
         case (wrState_ff)
            WR_IDLE: begin
               if (awTake) begin
                  awHeld_ff <= 1'b1;
                  awAddr_ff <= s_axi_awaddr;
               end
               if (wTake) begin
                  wHeld_ff <= 1'b1;
                  wData_ff <= s_axi_wdata;
                  wStrb_ff <= s_axi_wstrb;
               end
               s_axi_awready <= !haveAw;
               s_axi_wready <= !haveW;
               if (wrFire) begin
                  s_axi_awready <= 1'b0;
                  s_axi_wready <= 1'b0;
                  awHeld_ff <= 1'b0;
                  wHeld_ff <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= wrMapped ? 2'h0 : 2'h2;
                  wrState_ff <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wrState_ff <= WR_IDLE;
               end
            end
            default: wrState_ff <= WR_IDLE;
         endcase
         if (arTake) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= rdOk ? 2'h0 : 2'h2;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule // tlt_loop_alarm

// file: tlt_loop_alarm_sva.sv
`timescale 1ns/1ps
module tlt_loop_alarm_sva (
   // Clock and reset.
   input wire logic                ref_clk,
   input wire logic                rst,
   // Register bus.
   input wire logic                s_axi_awready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic [11:0]         s_axi_araddr,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   // Data, alarms and modes.
   input wire logic                system_tx_data_in,
   input wire logic                lineRxBit,
   input wire logic                receiverInBit,
   input wire logic                rxInFrame,
   input wire logic                forceOutOfFrame,
   input wire tlt_pkg::tlt_alarm_t realAlarm,
   input wire logic                sendRemoteAlarm,
   input wire logic                japanModeOut,
   input wire logic                crcIncludeFsDl,
   input wire logic                crcRemoteAlarmLenOut,
   input wire logic                remoteAlarmDetected
);
   import tlt_pkg::*;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##1 s_axi_awready)
      else $error("write response or ready recovery wrong");
   read_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read response or ready recovery wrong");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 12'h024 |=> s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   rx_source_a: assert property (receiverInBit |-> $past(lineRxBit) || $past(system_tx_data_in))
      else $error("receiver input from no source");
   oof_clear_a: assert property (forceOutOfFrame && rxInFrame |-> ##[1:3] !forceOutOfFrame)
      else $error("out of frame held after resync");
   j1_copies_a: assert property (japanModeOut == crcIncludeFsDl && japanModeOut == crcRemoteAlarmLenOut)
      else $error("mode outputs disagree");
   ra_mode_a: assert property (remoteAlarmDetected |-> japanModeOut || $past(japanModeOut))
      else $error("remote alarm detected outside japan mode");
   remote_send_a: assert property (sendRemoteAlarm |->
      $past(realAlarm.lossOfSignal) || $past(realAlarm.lossOfFrame))
      else $error("remote alarm sent without real cause");
endmodule // tlt_loop_alarm_sva

// file: tlt_loop_alarm_tb.sv
`timescale 1ns/1ps
`include "tlt_map.svh"
bind tlt_loop_alarm tlt_loop_alarm_sva chk_u (.ref_clk, .rst, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .system_tx_data_in,
   .lineRxBit, .receiverInBit, .rxInFrame, .forceOutOfFrame, .realAlarm, .sendRemoteAlarm, .japanModeOut,
   .crcIncludeFsDl, .crcRemoteAlarmLenOut, .remoteAlarmDetected);
module tlt_loop_alarm_tb;
   import tlt_pkg::*;
   logic        ref_clk, rst, bitStrobe, framingBitTime, dlBitTime, rxInFrame;
   logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdVal, e;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rdResp;
   logic [4:0]  slotIndex;
   logic [2:0]  bitIndex;
   logic [9:0]  cyc;
   logic [7:0]  bitPos;
   logic        system_tx_data_in, lineRxBit, coreRxBit, coreTxBit, receiverInBit, system_rx_data_out, lineTxBit;
   logic        realRxSlip, realTxSlip, realFrameErr, realCodeErr, realCrcErr;
   logic        sendRemoteAlarm, forceOutOfFrame, japanModeOut, crcIncludeFsDl, crcRemoteAlarmLenOut;
   logic        remoteAlarmDetected;
   tlt_alarm_t  realAlarm, reportAlarm;
   int          errorCnt, checks, tmo;
   // Each line bit lasts four clocks, so checks taken mid-bit are clear of the output register delay.
   assign bitPos = cyc[9:2];
   assign bitStrobe = cyc[1:0] == 2'h0;
   assign framingBitTime = bitPos == 8'h00;
   assign dlBitTime = framingBitTime;
   assign slotIndex = 5'((bitPos - 8'h01) >> 3);
   assign bitIndex = 3'(bitPos - 8'h01);
   tlt_loop_alarm dut_u (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bitStrobe, .slotIndex, .bitIndex,
      .framingBitTime, .dlBitTime, .rxInFrame, .system_tx_data_in, .lineRxBit, .coreRxBit, .coreTxBit,
      .receiverInBit, .system_rx_data_out, .lineTxBit, .realAlarm, .realRxSlip, .realTxSlip, .realFrameErr,
      .realCodeErr, .realCrcErr, .reportAlarm, .sendRemoteAlarm, .forceOutOfFrame, .japanModeOut, .crcIncludeFsDl,
      .crcRemoteAlarmLenOut, .remoteAlarmDetected);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cyc <= (cyc == 10'h303) ? 10'h000 : cyc + 10'h001;
      tmo <= tmo + 1;
      if (tmo == 60000) begin
         errorCnt++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (errorCnt == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checks++;
      if (g !== x) begin
         errorCnt++;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", 32'h0, 32'(s_axi_bresp));
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rdVal = s_axi_rdata;
      rdResp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
      rd(a);
      chk(n, x, rdVal);
   endtask
   task automatic at(input int p);
      do @(posedge ref_clk);
      while (cyc != 10'(p * 4 + 1));
      #1;
   endtask
   initial begin
      {cyc, rst, tmo} = {10'h0, 1'b1, 32'h0};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, rxInFrame} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {12'h0, 12'h0, 32'h0, 4'hf};
      {system_tx_data_in, lineRxBit, coreRxBit, coreTxBit, realAlarm} = '0;
      {realRxSlip, realTxSlip, realFrameErr, realCodeErr, realCrcErr} = '0;
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      rdc("ctrl", `TLT_ADDR_CTRL, 32'h0);
      rdc("loop", `TLT_ADDR_LOOP, 32'h0);
      rd(12'h040);
      chk("rresp", 32'h2, 32'(rdResp));
      for (int m = 0; m < 2; m++) begin
         wr(`TLT_ADDR_CTRL, m ? 32'h3 : 32'h1);
         repeat (4) @(posedge ref_clk);
         #1 chk("outOfFrame", 32'h1, 32'(forceOutOfFrame));
         for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            system_tx_data_in <= i[0];
            lineRxBit <= !i[0];
            coreTxBit <= i[1];
            repeat (2) @(posedge ref_clk);
            #1 chk("receiverIn", 32'(i[0]), 32'(receiverInBit));
            chk("lineTx", m ? 32'h1 : 32'(i[1]), 32'(lineTxBit));
         end
      end
      @(posedge ref_clk);
      rxInFrame <= 1'b1;
      repeat (4) @(posedge ref_clk);
      #1 chk("outOfFrame", 32'h0, 32'(forceOutOfFrame));
      wr(`TLT_ADDR_CTRL, 32'h0);
      wr(`TLT_ADDR_IDLE, 32'ha5);
      system_tx_data_in <= 1'b1;
      coreRxBit <= 1'b0;
      coreTxBit <= 1'b0;
      for (int s = 0; s < 24; s += 23) begin
         wr(`TLT_ADDR_LOOP, 32'h20 | s);
         for (int b = 0; b < 8; b++) begin
            at(s * 8 + 1 + b);
            chk("rxOut", 32'h1, 32'(system_rx_data_out));
            chk("lineTxIdle", 32'((8'ha5 >> (7 - b)) & 8'h01), 32'(lineTxBit));
         end
         at(41);
         chk("rxOutOther", 32'h0, 32'(system_rx_data_out));
         wr(`TLT_ADDR_LOOP, 32'(s));
         at(s * 8 + 1);
         chk("rxOutOff", 32'h0, 32'(system_rx_data_out));
      end
      @(posedge ref_clk);
      realAlarm <= 4'hf;
      wr(`TLT_ADDR_CTRL, 32'h10);
      // Two full passes: the first with the bipolar code and no extended framing, the second the other way round.
      for (int k = 1; k <= 18; k++) begin
         if (k == 10) wr(`TLT_ADDR_CTRL, 32'h8);
         wr(`TLT_ADDR_SIM, 32'h1);
         rdc("simCount", `TLT_ADDR_SIM, 32'((k % 9) << 1));
         e = (k % 9 == 0) ? 32'hf : (k % 9 <= 4 ? 32'(8 >> (k % 9 - 1)) : 32'h0);
         rdc("status", `TLT_ADDR_STATUS, e);
         chk("reportAlarm", e, 32'(reportAlarm));
         chk("remoteSend", 32'(k % 9 == 0), 32'(sendRemoteAlarm));
         if (k % 9 == 5) rdc("slip", `TLT_ADDR_SLIP, 32'h3);
         if (k % 9 == 5) rdc("slipClr", `TLT_ADDR_SLIP, 32'h0);
         if (k % 9 == 6) rdc("ferr", `TLT_ADDR_FERR, 32'h1);
         if (k % 9 == 6) rdc("ferrClr", `TLT_ADDR_FERR, 32'h0);
         if (k % 9 == 7) rdc("cverr", `TLT_ADDR_CVERR, 32'(k < 9));
         if (k % 9 == 8) rdc("crcerr", `TLT_ADDR_CRCERR, 32'(k > 9));
      end
      realAlarm <= 4'h0;
      // Start mid-frame so the first defect is not cleared by a framing bit before it is read back.
      at(100);
      for (int i = 0; i < 6; i++) begin
         wr(`TLT_ADDR_DEFECT, 32'h1 << i);
         rdc("defect", `TLT_ADDR_DEFECT, 32'h1 << i);
         if (i != 3 && i != 4) chk("lineTxDefect", 32'(i == 5), 32'(lineTxBit));
         at(1);
         rdc("defectClr", `TLT_ADDR_DEFECT, 32'h0);
      end
      wr(`TLT_ADDR_CTRL, 32'h4);
      lineRxBit <= 1'b1;
      coreRxBit <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1 chk("japanMode", 32'h1, 32'(japanModeOut));
      chk("crcFsDl", 32'h1, 32'(crcIncludeFsDl & crcRemoteAlarmLenOut));
      repeat (11) at(0);
      chk("raEarly", 32'h0, 32'(remoteAlarmDetected));
      repeat (3) at(0);
      chk("raDetect", 32'h1, 32'(remoteAlarmDetected));
      wr(`TLT_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 chk("japanOff", 32'h0, 32'(japanModeOut | remoteAlarmDetected));
      report_and_stop();
   end
endmodule // tlt_loop_alarm_tb
